//--- src/rtcfg_top.sv
// rtcfg_top: option registers of both remote terminals and their effect on
// mode command answers, self-test word choice and receive data storage.
// Assumes command decode, illegalization lookup and message checking upstream,
// all on clk_sys_i, with at most one command or data word per cycle.
`timescale 1ns/1ps
`default_nettype none
module rtcfg_top import rtcfg_pkg::*; #(
	parameter int TBUF_DEPTH = RTCFG_TBUF_WORDS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [RTCFG_AW-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [RTCFG_NUM_RT-1:0][15:0] dev_status_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_term_i,
	input wire logic cmd_bcast_i,
	input wire logic cmd_mode_i,
	input wire logic cmd_tr_i,
	input wire logic [4:0] cmd_modecode_i,
	input wire logic cmd_illegal_i,
	output logic resp_valid_o,
	output logic resp_has_data_o,
	output logic [15:0] resp_data_o,
	output logic msg_err_set_o,
	output logic status_upd_o,
	output logic cmd_ignored_o,
	output logic simplified_o,
	input wire logic rx_word_valid_i,
	input wire logic [15:0] rx_word_i,
	input wire logic msg_done_i,
	input wire logic msg_error_i,
	output logic mem_wr_o,
	output logic mem_term_o,
	output logic mem_bcast_area_o,
	output logic [$clog2(TBUF_DEPTH)-1:0] mem_idx_o,
	output logic [15:0] mem_data_o
);
	localparam int IW = $clog2(TBUF_DEPTH);

	// unpacked, so each terminal's process owns a separate element
	rtcfg_word_t cfg_ff [RTCFG_NUM_RT];
	rtcfg_word_t bitw_ff [RTCFG_NUM_RT];
	rtcfg_word_t altw_ff [RTCFG_NUM_RT];
	rtcfg_word_t bitw_view [RTCFG_NUM_RT];
	rtcfg_word_t sel_word [RTCFG_NUM_RT];

	// per-terminal register file
	for (genvar t = 0; t < RTCFG_NUM_RT; t++) begin : g_rt
		wire wr_cfg = reg_wr_i && (reg_addr_i == RTCFG_CFG_ADDR[t]);
		wire wr_bitw = reg_wr_i && (reg_addr_i == RTCFG_BITW_ADDR[t]);
		wire wr_altw = reg_wr_i && (reg_addr_i == RTCFG_ALTW_ADDR[t]);

		// device bits always show live status, the rest is software's
		assign bitw_view[t] = (bitw_ff[t] & ~RTCFG_BITW_DEV_MASK)
			| (dev_status_i[t] & RTCFG_BITW_DEV_MASK);
		assign sel_word[t] = cfg_ff[t][RTCFG_ALTBW_BIT] ? altw_ff[t] : bitw_view[t];

		always_ff @(posedge clk_sys_i) begin
			if (!rst_n_i) begin
				cfg_ff[t] <= RTCFG_CFG_RST;
				bitw_ff[t] <= RTCFG_BITW_RST;
				altw_ff[t] <= RTCFG_ALTW_RST;
			end else begin
				// reserved bit 10 is stored as written; software must keep it zero
				if (wr_cfg)
					cfg_ff[t] <= reg_wdata_i;
				if (wr_bitw)
					bitw_ff[t] <= reg_wdata_i;
				if (wr_altw)
					altw_ff[t] <= reg_wdata_i;
			end
		end
	end

	// register read, one cycle latency, unmapped offsets read zero
	rtcfg_word_t nxt_rdata;
	always_comb begin
		nxt_rdata = 16'h0000;
		for (int t = 0; t < RTCFG_NUM_RT; t++) begin
			if (reg_addr_i == RTCFG_CFG_ADDR[t])
				nxt_rdata = cfg_ff[t];
			if (reg_addr_i == RTCFG_BITW_ADDR[t])
				nxt_rdata = bitw_view[t];
			if (reg_addr_i == RTCFG_ALTW_ADDR[t])
				nxt_rdata = altw_ff[t];
		end
	end

	logic [15:0] rdata_ff;
	logic rvalid_ff;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd_i;
			if (reg_rd_i)
				rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata_o = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;

	// command evaluation uses the live fields, so a write applies from the next command
	wire rtcfg_word_t cur_cfg = cfg_ff[cmd_term_i];
	wire undef = cmd_mode_i && rtcfg_undef_mc(cmd_tr_i, cmd_modecode_i);
	wire drop = undef && cur_cfg[RTCFG_UNDEF_INV_BIT];
	wire accept = cmd_valid_i && !drop;
	wire illegal = cmd_mode_i && cmd_illegal_i;
	wire is_selftest = cmd_mode_i && cmd_tr_i && (cmd_modecode_i == RTCFG_MC_TX_SELFTEST);

	wire nxt_resp_valid = accept && !cmd_bcast_i;
	wire nxt_has_data = nxt_resp_valid && cmd_mode_i && !illegal
		&& cmd_tr_i && cmd_modecode_i[4];
	wire nxt_msg_err = accept && illegal;
	wire nxt_status_upd = accept;
	wire nxt_ignored = cmd_valid_i && drop;
	wire nxt_simplified = accept && cmd_mode_i && cur_cfg[RTCFG_SIMPL_BIT];
	// only the self-test word is sourced here; other mode data comes from elsewhere
	wire [15:0] nxt_resp_data = (nxt_has_data && is_selftest) ? sel_word[cmd_term_i] : 16'h0000;

	logic resp_valid_ff;
	logic has_data_ff;
	logic [15:0] resp_data_ff;
	logic msg_err_ff;
	logic status_upd_ff;
	logic ignored_ff;
	logic simplified_ff;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			resp_valid_ff <= 1'b0;
			has_data_ff <= 1'b0;
			resp_data_ff <= 16'h0000;
			msg_err_ff <= 1'b0;
			status_upd_ff <= 1'b0;
			ignored_ff <= 1'b0;
			simplified_ff <= 1'b0;
		end else begin
			resp_valid_ff <= nxt_resp_valid;
			has_data_ff <= nxt_has_data;
			resp_data_ff <= nxt_resp_data;
			msg_err_ff <= nxt_msg_err;
			status_upd_ff <= nxt_status_upd;
			ignored_ff <= nxt_ignored;
			simplified_ff <= nxt_simplified;
		end
	end
	assign resp_valid_o = resp_valid_ff;
	assign resp_has_data_o = has_data_ff;
	assign resp_data_o = resp_data_ff;
	assign msg_err_set_o = msg_err_ff;
	assign status_upd_o = status_upd_ff;
	assign cmd_ignored_o = ignored_ff;
	assign simplified_o = simplified_ff;

	// message context frozen at command acceptance, so mid-message writes cannot bite
	logic msg_term_ff;
	logic msg_bcast_ff;
	logic msg_sep_ff;
	logic msg_tmp_ff;
	logic [IW-1:0] dir_idx_ff;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			msg_term_ff <= 1'b0;
			msg_bcast_ff <= 1'b0;
			msg_sep_ff <= 1'b0;
			msg_tmp_ff <= 1'b0;
			dir_idx_ff <= '0;
		end else if (accept) begin
			msg_term_ff <= cmd_term_i;
			msg_bcast_ff <= cmd_bcast_i;
			msg_sep_ff <= cur_cfg[RTCFG_BSEP_BIT];
			msg_tmp_ff <= cur_cfg[RTCFG_TMPBUF_BIT];
			dir_idx_ff <= '0;
		end else if (rx_word_valid_i && !msg_tmp_ff) begin
			dir_idx_ff <= dir_idx_ff + IW'(1);
		end
	end

	rtcfg_buf_if #(.IW(IW)) tb_if ();
	assign tb_if.clr = accept;
	assign tb_if.wr = rx_word_valid_i && msg_tmp_ff;
	assign tb_if.wdata = rx_word_i;
	assign tb_if.done = msg_done_i && msg_tmp_ff;
	assign tb_if.err = msg_error_i;

	rtcfg_tmpbuf #(.DEPTH(TBUF_DEPTH)) u_tmpbuf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.bi(tb_if)
	);

	// without the temporary buffer words go straight to the subaddress buffer
	wire dir_wr = rx_word_valid_i && !msg_tmp_ff;
	wire nxt_mem_wr = dir_wr || tb_if.out_wr;
	wire [IW-1:0] nxt_mem_idx = dir_wr ? dir_idx_ff : tb_if.out_idx;
	wire [15:0] nxt_mem_data = dir_wr ? rx_word_i : tb_if.out_data;
	wire nxt_bcast_area = msg_bcast_ff && msg_sep_ff;

	logic mem_wr_ff;
	logic mem_term_ff;
	logic mem_bcast_ff;
	logic [IW-1:0] mem_idx_ff;
	logic [15:0] mem_data_ff;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mem_wr_ff <= 1'b0;
			mem_term_ff <= 1'b0;
			mem_bcast_ff <= 1'b0;
			mem_idx_ff <= '0;
			mem_data_ff <= 16'h0000;
		end else begin
			mem_wr_ff <= nxt_mem_wr;
			mem_term_ff <= msg_term_ff;
			mem_bcast_ff <= nxt_bcast_area;
			mem_idx_ff <= nxt_mem_idx;
			mem_data_ff <= nxt_mem_data;
		end
	end
	assign mem_wr_o = mem_wr_ff;
	assign mem_term_o = mem_term_ff;
	assign mem_bcast_area_o = mem_bcast_ff;
	assign mem_idx_o = mem_idx_ff;
	assign mem_data_o = mem_data_ff;
endmodule
`default_nettype wire

//--- src/rtcfg_pkg.sv
// rtcfg_pkg: constants and types for the per-terminal option registers.
// Assumes a 16-bit register port with word addresses and two remote terminals.
package rtcfg_pkg;

	localparam int RTCFG_NUM_RT = 2;
	localparam int RTCFG_AW = 8;
	localparam int RTCFG_DW = 16;

	typedef logic [RTCFG_DW-1:0] rtcfg_word_t;
	typedef logic [RTCFG_AW-1:0] rtcfg_addr_t;

	// per-terminal register offsets, index 0 is the first terminal
	localparam rtcfg_addr_t [RTCFG_NUM_RT-1:0] RTCFG_CFG_ADDR = {8'h20, 8'h17};
	localparam rtcfg_addr_t [RTCFG_NUM_RT-1:0] RTCFG_BITW_ADDR = {8'h27, 8'h1E};
	localparam rtcfg_addr_t [RTCFG_NUM_RT-1:0] RTCFG_ALTW_ADDR = {8'h28, 8'h1F};

	// configuration field positions
	localparam int RTCFG_RSVD_BIT = 10;
	localparam int RTCFG_UNDEF_INV_BIT = 9;
	localparam int RTCFG_BSEP_BIT = 8;
	localparam int RTCFG_SIMPL_BIT = 7;
	localparam int RTCFG_TMPBUF_BIT = 6;
	localparam int RTCFG_ALTBW_BIT = 5;

	// reset values
	localparam rtcfg_word_t RTCFG_CFG_RST = 16'h0000;
	localparam rtcfg_word_t RTCFG_BITW_RST = 16'h0000;
	localparam rtcfg_word_t RTCFG_ALTW_RST = 16'h0000;

	// bits of the default self-test word owned by the device, not by software
	localparam rtcfg_word_t RTCFG_BITW_DEV_MASK = 16'hF000;

	localparam int RTCFG_TBUF_WORDS = 32;
	localparam logic [4:0] RTCFG_MC_TX_SELFTEST = 5'h13;

	// undefined mode codes that the invalid option may suppress
	function automatic logic rtcfg_undef_mc(input logic tr, input logic [4:0] mc);
		if (!tr)
			return (mc <= 5'h0F) || (mc == 5'h10) || (mc == 5'h12) || (mc == 5'h13);
		return (mc == 5'h11) || (mc == 5'h14) || (mc == 5'h15);
	endfunction

endpackage

//--- src/rtcfg_buf_if.sv
// rtcfg_buf_if: carries receive words into the temporary buffer and copies out.
// Assumes one owner of each modport on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface rtcfg_buf_if #(parameter int IW = 5);
	logic clr;
	logic wr;
	logic [15:0] wdata;
	logic done;
	logic err;
	logic out_wr;
	logic [IW-1:0] out_idx;
	logic [15:0] out_data;
	logic busy;

	modport ctl (output clr, output wr, output wdata, output done, output err,
		input out_wr, input out_idx, input out_data, input busy);
	modport buf_side (input clr, input wr, input wdata, input done, input err,
		output out_wr, output out_idx, output out_data, output busy);
endinterface
`default_nettype wire

//--- src/rtcfg_tmpbuf.sv
// rtcfg_tmpbuf: temporary receive buffer, copies out only after a clean message.
// Assumes the controller clears it at each command start and never writes while busy.
`timescale 1ns/1ps
`default_nettype none
module rtcfg_tmpbuf import rtcfg_pkg::*; #(
	parameter int DEPTH = RTCFG_TBUF_WORDS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	rtcfg_buf_if.buf_side bi
);
	localparam int IW = $clog2(DEPTH);

	typedef enum {TB_FILL, TB_COPY} rtcfg_tb_state_t;

	logic [15:0] mem [DEPTH];
	rtcfg_tb_state_t state_ff;
	logic [IW:0] cnt_ff;
	logic [IW-1:0] rd_ff;
	logic out_wr_ff;
	logic [IW-1:0] out_idx_ff;
	logic [15:0] out_data_ff;

	wire room = (cnt_ff < (IW+1)'(DEPTH));
	wire last = ({1'b0, rd_ff} == cnt_ff - (IW+1)'(1));

	always_ff @(posedge clk_sys_i) begin
		if (bi.wr && room && state_ff == TB_FILL)
			mem[cnt_ff[IW-1:0]] <= bi.wdata;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_ff <= TB_FILL;
			cnt_ff <= '0;
			rd_ff <= '0;
			out_wr_ff <= 1'b0;
			out_idx_ff <= '0;
			out_data_ff <= 16'h0000;
		end else begin
			out_wr_ff <= 1'b0;
			case (state_ff)
				TB_FILL: begin
					if (bi.clr) begin
						cnt_ff <= '0;
					end else if (bi.done) begin
						// an errored message leaves the subaddress buffer untouched
						if (!bi.err && cnt_ff != '0) begin
							state_ff <= TB_COPY;
							rd_ff <= '0;
						end else begin
							cnt_ff <= '0;
						end
					end else if (bi.wr && room) begin
						cnt_ff <= cnt_ff + (IW+1)'(1);
					end
				end
				TB_COPY: begin
					out_wr_ff <= 1'b1;
					out_idx_ff <= rd_ff;
					out_data_ff <= mem[rd_ff];
					rd_ff <= rd_ff + IW'(1);
					if (last) begin
						state_ff <= TB_FILL;
						cnt_ff <= '0;
					end
				end
				default: state_ff <= TB_FILL;
			endcase
		end
	end

	assign bi.out_wr = out_wr_ff;
	assign bi.out_idx = out_idx_ff;
	assign bi.out_data = out_data_ff;
	assign bi.busy = (state_ff == TB_COPY);
endmodule
`default_nettype wire

//--- verification/rtcfg_chk_sva.sv
// rtcfg_chk: port-level timing relations of the option register block.
// Assumes a bind to rtcfg_top; command fields are qualified by cmd_valid_i.
`timescale 1ns/1ps
`default_nettype none
module rtcfg_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_rd_i,
	input wire logic reg_rvalid_o,
	input wire logic cmd_valid_i,
	input wire logic cmd_bcast_i,
	input wire logic cmd_mode_i,
	input wire logic cmd_tr_i,
	input wire logic [4:0] cmd_modecode_i,
	input wire logic cmd_illegal_i,
	input wire logic resp_valid_o,
	input wire logic resp_has_data_o,
	input wire logic msg_err_set_o,
	input wire logic status_upd_o,
	input wire logic cmd_ignored_o,
	input wire logic simplified_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire logic undef;
	wire logic mcmd;
	wire logic mu;
	assign undef = cmd_tr_i ? (cmd_modecode_i inside {5'h11, 5'h14, 5'h15}) :
		(cmd_modecode_i <= 5'h13 && cmd_modecode_i != 5'h11);
	assign mcmd = cmd_valid_i && cmd_mode_i;
	assign mu = mcmd && undef;
	a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered next cycle");
	a_rvalid_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read data valid without a read");
	a_ignored_quiet: assert property (cmd_ignored_o |->
		!(resp_valid_o || status_upd_o || msg_err_set_o || simplified_o))
		else $error("ignored command still answered");
	a_ignore_cause: assert property (cmd_ignored_o |-> $past(mu))
		else $error("ignored a command outside the undefined list");
	a_defined_kept: assert property (mcmd && !undef |=> !cmd_ignored_o && status_upd_o)
		else $error("defined mode command not accepted");
	a_bcast_silent: assert property (cmd_valid_i && cmd_bcast_i |=> !resp_valid_o)
		else $error("status sent for broadcast");
	a_illegal_err: assert property (mcmd && cmd_illegal_i && !undef |=>
		msg_err_set_o ##0 !resp_has_data_o) else $error("illegal mode command handled wrong");
	a_legal_resp: assert property (mcmd && !cmd_illegal_i && !cmd_bcast_i |=>
		cmd_ignored_o || (resp_valid_o && status_upd_o && !msg_err_set_o))
		else $error("no normal answer");
	a_simpl_cause: assert property (simplified_o |-> $past(mcmd))
		else $error("simplified flag without mode command");
	a_quiet_idle: assert property (!cmd_valid_i |=> !(resp_valid_o || status_upd_o))
		else $error("answer without command");
endmodule
`default_nettype wire

//--- verification/rtcfg_bc_model.sv
// rtcfg_bc_model: bus controller side, issues commands and receive words.
// Assumes its tasks are called at a falling clock edge, one at a time.
`timescale 1ns/1ps
`default_nettype none
module rtcfg_bc_model (
	input wire logic clk_sys_i,
	output logic cmd_valid_o,
	output logic [9:0] cmd_o,
	output logic rx_valid_o,
	output logic [15:0] rx_o,
	output logic done_o,
	output logic err_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = 10'h000;
		rx_valid_o = 1'b0;
		rx_o = 16'h0000;
		done_o = 1'b0;
		err_o = 1'b0;
	end
	// fields go inverted after each pulse so a stale value is never mistaken for a hold
	task automatic cmd(input logic [9:0] c);
		cmd_o = c;
		cmd_valid_o = 1'b1;
		@(negedge clk_sys_i);
		cmd_valid_o = 1'b0;
		cmd_o = ~c;
	endtask
	task automatic msg(input logic [15:0] w0, input logic [15:0] w1, input logic e);
		rx_valid_o = 1'b1;
		rx_o = w0;
		@(negedge clk_sys_i);
		rx_o = w1;
		@(negedge clk_sys_i);
		rx_valid_o = 1'b0;
		rx_o = ~w1;
		done_o = 1'b1;
		err_o = e;
		@(negedge clk_sys_i);
		done_o = 1'b0;
		err_o = ~e;
	endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// testbench: register and command sequences against the option register block.
// Assumes rtcfg_pkg, rtcfg_top, rtcfg_bc_model and rtcfg_chk compiled before.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench import rtcfg_pkg::*; ;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	rtcfg_addr_t reg_addr_i = 8'h00;
	rtcfg_word_t reg_wdata_i = 16'h0000;
	logic [1:0][15:0] dev_st = {16'hC000, 16'h5000};
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [22:0] memq[$];
	wire logic cv, rv, dn, er;
	wire logic [9:0] cf;
	wire logic [15:0] rw, reg_rdata_o, resp_data_o, mem_data_o;
	wire logic reg_rvalid_o, resp_valid_o, resp_has_data_o, msg_err_set_o, status_upd_o;
	wire logic cmd_ignored_o, simplified_o, mem_wr_o, mem_term_o, mem_bcast_area_o;
	wire logic [4:0] mem_idx_o;
	wire logic [5:0] fl = {resp_valid_o, resp_has_data_o, msg_err_set_o, status_upd_o,
		cmd_ignored_o, simplified_o};
	rtcfg_top DUT (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
		.reg_rdata_o, .reg_rvalid_o, .dev_status_i(dev_st), .cmd_valid_i(cv), .cmd_term_i(cf[9]),
		.cmd_bcast_i(cf[8]), .cmd_mode_i(cf[7]), .cmd_tr_i(cf[6]), .cmd_modecode_i(cf[5:1]),
		.cmd_illegal_i(cf[0]), .resp_valid_o, .resp_has_data_o, .resp_data_o, .msg_err_set_o,
		.status_upd_o, .cmd_ignored_o, .simplified_o, .rx_word_valid_i(rv), .rx_word_i(rw),
		.msg_done_i(dn), .msg_error_i(er), .mem_wr_o, .mem_term_o, .mem_bcast_area_o, .mem_idx_o,
		.mem_data_o);
	rtcfg_bc_model bfm (.clk_sys_i, .cmd_valid_o(cv), .cmd_o(cf), .rx_valid_o(rv), .rx_o(rw),
		.done_o(dn), .err_o(er));
	always #10 clk_sys_i = ~clk_sys_i;
	// sampled mid-cycle, where the registered buffer writes have settled
	always @(negedge clk_sys_i) begin
		cyc++;
		if (mem_wr_o === 1'b1)
			memq.push_back({mem_term_o, mem_bcast_area_o, mem_idx_o, mem_data_o});
		if (cyc == 5000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input rtcfg_addr_t a, input rtcfg_word_t d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		reg_wdata_i = ~d;
		@(negedge clk_sys_i);
	endtask
	task automatic rd(input rtcfg_addr_t a, input rtcfg_word_t e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		`CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, e})
		@(negedge clk_sys_i);
	endtask
	task automatic selftest(input logic t, input rtcfg_word_t e);
		bfm.cmd({t, 3'b011, 5'h13, 1'b0});
		`CHK({resp_valid_o, resp_has_data_o, resp_data_o}, {2'b11, e})
		@(negedge clk_sys_i);
	endtask
	task automatic sweep(input logic inv);
		logic [4:0] mc;
		logic [5:0] e;
		logic u, ok, bc, il;
		wr(8'h17, {6'h00, inv, 1'b0, inv, 7'h00});
		wr(8'h20, {6'h00, inv, 1'b0, inv, 7'h00});
		for (int i = 0; i < 128; i++) begin
			mc = i[5:1];
			u = i[6] ? (mc inside {5'h11, 5'h14, 5'h15}) : (mc <= 5'h13 && mc != 5'h11);
			ok = !(inv && u);
			bc = i[2] & i[4];
			il = i[1] ^ i[3];
			e = {ok & !bc, ok & !bc & !il & i[6] & mc[4], ok & il, ok, !ok, ok & inv};
			bfm.cmd({i[0], bc, 1'b1, i[6], mc, il});
			`CHK(fl, e)
			@(negedge clk_sys_i);
		end
	endtask
	// receive command to subaddress 1 with two data words, then a settle gap
	task automatic rx_msg(input logic t, input logic b, input logic e);
		memq.delete();
		bfm.cmd({t, b, 8'h02});
		bfm.msg(16'hA5C3, 16'h3C5A, e);
		repeat (6) @(negedge clk_sys_i);
	endtask
	function automatic logic [46:0] pair(input logic t, input logic b);
		return {1'b1, t, b, 5'h00, 16'hA5C3, t, b, 5'h01, 16'h3C5A};
	endfunction
	initial begin
		repeat (16) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		rd(8'h17, 16'h0000);
		rd(8'h20, 16'h0000);
		rd(8'h1E, 16'h5000);
		rd(8'h27, 16'hC000);
		rd(8'h30, 16'h0000);
		$display("test reset done");
		wr(8'h17, 16'hFBFF);
		rd(8'h17, 16'hFBFF);
		rd(8'h20, 16'h0000);
		wr(8'h1E, 16'hFFFF);
		rd(8'h1E, 16'h5FFF);
		wr(8'h1F, 16'hABCD);
		wr(8'h28, 16'h1234);
		wr(8'h3F, 16'hFFFF);
		rd(8'h3F, 16'h0000);
		rd(8'h28, 16'h1234);
		$display("test registers done");
		wr(8'h17, 16'h0000);
		selftest(1'b0, 16'h5FFF);
		dev_st[0] = 16'h3000;
		selftest(1'b0, 16'h3FFF);
		wr(8'h17, 16'h0020);
		selftest(1'b0, 16'hABCD);
		wr(8'h20, 16'h0000);
		selftest(1'b1, 16'hC000);
		wr(8'h20, 16'h0020);
		selftest(1'b1, 16'h1234);
		$display("test selftest word done");
		sweep(1'b0);
		sweep(1'b1);
		$display("test mode codes done");
		wr(8'h17, 16'h0000);
		rx_msg(1'b0, 1'b1, 1'b0);
		`CHK({memq.size() == 2, memq[0], memq[1]}, pair(1'b0, 1'b0))
		wr(8'h17, 16'h0100);
		rx_msg(1'b0, 1'b1, 1'b0);
		`CHK({memq.size() == 2, memq[0], memq[1]}, pair(1'b0, 1'b1))
		// a write in mid-message must not move the words of that message
		fork
			rx_msg(1'b0, 1'b1, 1'b0);
			begin
				repeat (2) @(negedge clk_sys_i);
				wr(8'h17, 16'h0000);
			end
		join
		`CHK({memq.size() == 2, memq[0], memq[1]}, pair(1'b0, 1'b1))
		rx_msg(1'b0, 1'b1, 1'b0);
		`CHK({memq.size() == 2, memq[0], memq[1]}, pair(1'b0, 1'b0))
		wr(8'h20, 16'h0040);
		rx_msg(1'b1, 1'b0, 1'b1);
		`CHK(memq.size(), 0)
		rx_msg(1'b1, 1'b0, 1'b0);
		`CHK({memq.size() == 2, memq[0], memq[1]}, pair(1'b1, 1'b0))
		$display("test receive data done");
		end_of_test();
	end
endmodule
bind rtcfg_top rtcfg_chk u_chk (.clk_sys_i, .rst_n_i, .reg_rd_i, .reg_rvalid_o, .cmd_valid_i,
	.cmd_bcast_i, .cmd_mode_i, .cmd_tr_i, .cmd_modecode_i, .cmd_illegal_i, .resp_valid_o,
	.resp_has_data_o, .msg_err_set_o, .status_upd_o, .cmd_ignored_o, .simplified_o);
`default_nettype wire
